// File: test/io_port_mode_sva.sv
`timescale 1ns/1ps
// ****
// Port mode checker.
// ****
module io_port_mode_sva #(
    parameter logic [15:0] RESET_PATTERN = 16'h0000,
    parameter bit RESET_PATTERN_MODE = 1'b0
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic ADDRESS_STROBE,
    input wire logic [55:0] ARRAY_OE,
    input wire logic CPU_RESET,
    input wire logic BUS_CYCLE_ACTIVE,
    input wire logic [2:0] JTAG_ENABLE_SRC,
    input wire logic JTAG_ACTIVE,
    input wire logic [55:0] PIN_OUT,
    input wire logic [55:0] PIN_OE,
    input wire logic [55:0] ARRAY_IN,
    input wire logic [55:0] ADDR_INPUT_FLAG
);
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (SRST);
    AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not zero-wait OKAY");
    AST_ABC_OE_TERM: assert property ((ARRAY_OE[23:0] & ~PIN_OE[23:0]) == 24'h0)
        else $error("array enable term did not enable driver");
    AST_G_OE_TERM: assert property ((ARRAY_OE[55:48] & ~PIN_OE[55:48]) == 8'h0)
        else $error("port G enable term did not enable driver");
    AST_RESET_CLEARS: assert property ($fell(SRST) |-> PIN_OE[23:0] == ARRAY_OE[23:0] && HRDATA == 32'h0)
        else $error("state not cleared by reset");
    AST_JTAG_ANY: assert property (JTAG_ACTIVE == |JTAG_ENABLE_SRC)
        else $error("jtag enable not the OR of its sources");
    AST_ADDR_FLAG_CONST: assert property ($stable(ADDR_INPUT_FLAG) && ADDR_INPUT_FLAG[27:0] == 28'hfffffff)
        else $error("address input flags changed");
    // The strobe passes two sync stages, so the hold is judged after five low cycles.
    AST_STROBE_HOLD: assert property (!ADDRESS_STROBE [*5] |=> $stable(ARRAY_IN))
        else $error("array inputs moved while strobe low");
    AST_RESET_PATTERN: assert property (CPU_RESET [*3] ##0 (RESET_PATTERN_MODE && !BUS_CYCLE_ACTIVE)
        |-> PIN_OE[55:40] == 16'hffff && PIN_OUT[55:40] == RESET_PATTERN)
        else $error("reset pattern not driven");
    COV_PATTERN: cover property (CPU_RESET [*3] ##0 !BUS_CYCLE_ACTIVE);
    COV_STROBE: cover property (ADDRESS_STROBE ##1 !ADDRESS_STROBE);
    COV_JTAG: cover property (JTAG_ACTIVE);
endmodule
bind io_port_mode_selection io_port_mode_sva #(.RESET_PATTERN(RESET_PATTERN),
    .RESET_PATTERN_MODE(RESET_PATTERN_MODE)) u_sva (.CLK, .SRST, .HRDATA, .HREADYOUT, .HRESP,
    .ADDRESS_STROBE, .ARRAY_OE, .CPU_RESET, .BUS_CYCLE_ACTIVE, .JTAG_ENABLE_SRC, .JTAG_ACTIVE,
    .PIN_OUT, .PIN_OE, .ARRAY_IN, .ADDR_INPUT_FLAG);

// File: test/pin_partner.sv
`timescale 1ns/1ps
// ****
// Far side: pins and the processor.
// ****
module pin_partner (
    input wire logic [55:0] pin_out,
    input wire logic [55:0] pin_oe,
    input wire logic [55:0] ext_level,
    input wire logic cpu_reset,
    output logic [55:0] pin_in,
    output logic [15:0] boot_pattern
);
    // Undriven pins show the external device's level, never the block's stale output.
    always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
    always @(negedge cpu_reset) boot_pattern <= pin_in[55:40];
endmodule

// File: test/test_io_port_mode_selection.sv
`timescale 1ns/1ps
// ****
// Bench.
// ****
module test_io_port_mode_selection;
    import port_mode_pkg::*;
    localparam logic [15:0] PATTERN = 16'hc35a;
    logic clk, srst, hsel, hwrite, strobe, sel_a, sel_b, cpu_oe, cpu_reset, hreadyout, hresp, jtag_act, bus_act;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] jtag_src;
    logic [15:0] mux_addr, cpu_dout, boot, cpu_din;
    logic [55:0] array_oe, pin_in, pin_out, pin_oe, ext, array_in, addr_flag;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [23:0] rows [12] = '{{OFF_DIR_A, 16'ha5a5}, {OFF_DIR_B, 16'h3c3c}, {OFF_DIR_C, 16'h8181},
        {OFF_DIR_E, 16'h7e7e}, {OFF_DIR_F, 16'h0101}, {OFF_DIR_G, 16'h8080}, {OFF_CTRL_E, 16'hffff},
        {OFF_CTRL_F, 16'h0f0f}, {OFF_CTRL_G, 16'hf0f0}, {OFF_DATA_OUT_A, 16'h9696},
        {OFF_MEM_MAP, 16'h8080}, {8'h5c, 16'hff00}};
    io_port_mode_selection #(.RESET_PATTERN(PATTERN), .RESET_PATTERN_MODE(1'b1)) dut (.CLK(clk),
        .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(HSIZE_WORD),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .MUX_ADDR(mux_addr), .ADDRESS_STROBE(strobe), .ARRAY_OUT(56'h0), .ARRAY_OE(array_oe),
        .PERIPHERAL_SELECT_TERM_A(sel_a), .PERIPHERAL_SELECT_TERM_B(sel_b), .CPU_DATA_OUT(cpu_dout),
        .CPU_DATA_OE(cpu_oe), .CPU_DATA_IN(cpu_din), .CPU_RESET(cpu_reset), .BUS_CYCLE_ACTIVE(bus_act),
        .JTAG_ENABLE_SRC(jtag_src), .JTAG_ACTIVE(jtag_act), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe), .ARRAY_IN(array_in), .ADDR_INPUT_FLAG(addr_flag));
    pin_partner u_far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .cpu_reset(cpu_reset),
        .pin_in(pin_in), .boot_pattern(boot));
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task final_report;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        final_report;
    end
    initial
    begin
        {srst, hsel, hwrite, strobe, sel_a, sel_b, cpu_oe, cpu_reset, bus_act} = 9'h100;
        {haddr, hwdata, htrans, jtag_src, mux_addr, cpu_dout, array_oe} = '0;
        ext = 56'h1e2d3c4b5a6978;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        xfer(1'b0, OFF_DIR_A, 8'h0);
        chk(64'(rd), 64'h0);
        xfer(1'b0, OFF_CTRL_G, 8'h0);
        chk(64'(rd), 64'h0);
        chk(64'(pin_oe), 64'h0);
        foreach (rows[i])
        begin
            xfer(1'b1, rows[i][23:16], rows[i][15:8]);
            xfer(1'b0, rows[i][23:16], 8'h0);
            chk(64'(rd), 64'(rows[i][7:0]));
        end
        xfer(1'b1, OFF_DATA_OUT_A, 8'h5a);
        xfer(1'b1, OFF_DIR_A, 8'hff);
        xfer(1'b1, OFF_DIR_B, 8'h00);
        xfer(1'b1, OFF_DIR_C, 8'h00);
        wt(1);
        chk(64'({pin_oe[7:0], pin_out[7:0]}), 64'hff5a);
        xfer(1'b0, OFF_PIN_IN_B, 8'h0);
        chk(64'(rd), 64'h69);
        xfer(1'b0, OFF_PIN_IN_A, 8'h0);
        chk(64'(rd), 64'h5a);
        array_oe <= 56'h0f0000;
        wt(1);
        chk(64'(pin_oe[23:16]), 64'h0f);
        @(posedge clk);
        array_oe <= '0;
        wt(1);
        chk(64'(pin_oe[23:16]), 64'h00);
        xfer(1'b1, OFF_MEM_MAP, 8'h00);
        foreach (rows[i])
            if (i < 9)
                xfer(1'b1, rows[i][23:16], 8'hff);
        @(posedge clk);
        mux_addr <= 16'hbeef;
        strobe <= 1'b1;
        repeat (4) @(posedge clk);
        strobe <= 1'b0;
        repeat (4) @(posedge clk);
        mux_addr <= 16'h1234;
        wt(4);
        chk(64'({pin_oe[55:32], pin_out[55:32]}), 64'hffffffbeefef);
        chk(64'(array_in[31:0]), 64'h4b00005a);
        chk(64'(addr_flag), 64'h0fff_ffff);
        xfer(1'b1, OFF_CTRL_F, 8'h00);
        xfer(1'b1, OFF_MEM_MAP, 8'h80);
        wt(2);
        chk(64'(pin_oe[47:40]), 64'h00);
        for (int j = 0; j < 2; j++)
        begin
            @(posedge clk);
            {sel_b, sel_a} <= 2'(j + 1);
            cpu_oe <= 1'b1;
            cpu_dout <= 16'h00c3;
            wt(3);
            chk(64'({pin_oe[47:40], pin_out[47:40]}), 64'hffc3);
            chk(64'(cpu_din), 64'h00c3);
        end
        @(posedge clk);
        {sel_b, sel_a} <= 2'b00;
        wt(1);
        chk(64'(pin_oe[47:40]), 64'h00);
        for (int j = 0; j < 8; j++)
        begin
            @(posedge clk);
            jtag_src <= 3'(j);
            wt(1);
            chk(64'(jtag_act), 64'(j != 0));
        end
        xfer(1'b1, OFF_MEM_MAP, 8'h00);
        foreach (rows[i])
            if (i > 3 && i < 9)
                xfer(1'b1, rows[i][23:16], 8'h00);
        @(posedge clk);
        cpu_reset <= 1'b1;
        wt(5);
        chk(64'({pin_oe[55:40], pin_out[55:40]}), 64'({16'hffff, PATTERN}));
        @(posedge clk);
        bus_act <= 1'b1;
        wt(1);
        chk(64'(pin_oe[55:40]), 64'h0);
        @(posedge clk);
        bus_act <= 1'b0;
        wt(1);
        chk(64'(pin_oe[55:40]), 64'hffff);
        @(posedge clk);
        cpu_reset <= 1'b0;
        wt(5);
        chk(64'(pin_oe[55:40]), 64'h0);
        chk(64'(boot), 64'(PATTERN));
        xfer(1'b1, OFF_DATA_OUT_E, 8'ha5);
        xfer(1'b1, OFF_DIR_E, 8'hff);
        wt(1);
        chk(64'({pin_oe[39:32], pin_out[39:32]}), 64'hffa5);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        wt(1);
        chk(64'(pin_oe[39:32]), 64'h0);
        xfer(1'b0, OFF_DIR_E, 8'h0);
        chk(64'(rd), 64'h0);
        final_report;
    end
endmodule

// File: verilog/io_port_mode_selection.sv
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps

module io_port_mode_selection
    import port_mode_pkg::*;
#(
    parameter logic [7:0] PLA_ARRAY_A = 8'h00,
    parameter logic [7:0] PLA_ARRAY_B = 8'h00,
    parameter logic [7:0] PLA_ARRAY_C = 8'h00,
    parameter logic [7:0] ADDR_IN_MASK_F = 8'h00,
    parameter logic [15:0] RESET_PATTERN = 16'h0000,
    parameter bit DATA_PORT_MODE = 1'b0,
    parameter bit RESET_PATTERN_MODE = 1'b0,
    parameter bit BURST_FETCH = 1'b0
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [15:0] MUX_ADDR,
    input wire logic ADDRESS_STROBE,
    input wire logic [55:0] ARRAY_OUT,
    input wire logic [55:0] ARRAY_OE,
    input wire logic PERIPHERAL_SELECT_TERM_A,
    input wire logic PERIPHERAL_SELECT_TERM_B,
    input wire logic [15:0] CPU_DATA_OUT,
    input wire logic CPU_DATA_OE,
    output logic [15:0] CPU_DATA_IN,
    input wire logic CPU_RESET,
    input wire logic BUS_CYCLE_ACTIVE,
    input wire logic [2:0] JTAG_ENABLE_SRC,
    output logic JTAG_ACTIVE,
    input wire logic [55:0] PIN_IN,
    output logic [55:0] PIN_OUT,
    output logic [55:0] PIN_OE,
    output logic [55:0] ARRAY_IN,
    output logic [55:0] ADDR_INPUT_FLAG
);

    // ******************************************************************
    // Register bus
    // ******************************************************************

    logic [7:0] dout_q [7];
    logic [7:0] dir_q [7];
    logic [7:0] ctrl_q [3];
    logic [7:0] mem_map_q;
    logic [55:0] pin_s;
    logic [55:0] array_in_q;
    logic [15:0] addr_latch_q;
    logic [15:0] mux_addr_s;
    logic [1:0] strobe_q;
    logic [1:0] cpu_reset_q;
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic access_ok;

    function automatic logic is_port_reg(input logic [7:0] a, input logic [7:0] base, input int idx);
        is_port_reg = (a == 8'(base + 8'(idx * 4)));
    endfunction

    assign access_ok = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ) && (HSIZE == HSIZE_WORD);
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= access_ok && HWRITE;
            rd_pend_q <= access_ok && !HWRITE;
            addr_q <= HADDR[7:0];
        end
    end

    // Reset clears every configuration bit, so pins start as inputs unless ARRAY_OE, CPU_DATA_OE (DATA_PORT_MODE) or the reset pattern enables them.
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            for (int i = 0; i < 7; i++)
            begin
                dout_q[i] <= PORT_RESET;
                dir_q[i] <= PORT_RESET;
            end
            for (int i = 0; i < 3; i++)
            begin
                ctrl_q[i] <= PORT_RESET;
            end
            mem_map_q <= MEM_MAP_RESET;
        end
        else if (wr_pend_q)
        begin
            for (int i = 0; i < 7; i++)
            begin
                if (is_port_reg(addr_q, OFF_DATA_OUT_A, i))
                begin
                    dout_q[i] <= HWDATA[7:0];
                end
                if (is_port_reg(addr_q, OFF_DIR_A, i))
                begin
                    // Port D has only four pins.
                    dir_q[i] <= (i == 3) ? {4'h0, HWDATA[3:0]} : HWDATA[7:0];
                end
            end
            for (int i = 0; i < 3; i++)
            begin
                if (is_port_reg(addr_q, OFF_CTRL_E, i))
                begin
                    ctrl_q[i] <= HWDATA[7:0];
                end
            end
            if (addr_q == OFF_MEM_MAP)
            begin
                mem_map_q <= HWDATA[7:0];
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            HRDATA <= 32'h0000_0000;
        end
        else if (access_ok && !HWRITE)
        begin
            HRDATA <= 32'h0000_0000;
            for (int i = 0; i < 7; i++)
            begin
                if (is_port_reg(HADDR[7:0], OFF_DATA_OUT_A, i))
                begin
                    HRDATA <= {24'h0, dout_q[i]};
                end
                if (is_port_reg(HADDR[7:0], OFF_DIR_A, i))
                begin
                    HRDATA <= {24'h0, dir_q[i]};
                end
                if (is_port_reg(HADDR[7:0], OFF_PIN_IN_A, i))
                begin
                    HRDATA <= {24'h0, pin_s[i*8 +: 8]};
                end
            end
            for (int i = 0; i < 3; i++)
            begin
                if (is_port_reg(HADDR[7:0], OFF_CTRL_E, i))
                begin
                    HRDATA <= {24'h0, ctrl_q[i]};
                end
            end
            if (HADDR[7:0] == OFF_MEM_MAP)
            begin
                HRDATA <= {24'h0, mem_map_q};
            end
            if (HADDR[7:0] == OFF_ADDR_LATCH)
            begin
                HRDATA <= {16'h0, addr_latch_q};
            end
        end
    end

    // ******************************************************************
    // Pin input path
    // ******************************************************************

    pin_sync #(
        .WIDTH(56)
    ) u_pin_sync (
        .CLK(CLK),
        .SRST(SRST),
        .async_in(PIN_IN),
        .sync_out(pin_s)
    );

    // The multiplexed address passes the same two stages as the strobe, so
    // both arrive in step at the address latch.
    pin_sync #(
        .WIDTH(16)
    ) u_addr_sync (
        .CLK(CLK),
        .SRST(SRST),
        .async_in(MUX_ADDR),
        .sync_out(mux_addr_s)
    );

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            strobe_q <= 2'b00;
            cpu_reset_q <= 2'b00;
        end
        else
        begin
            strobe_q <= {strobe_q[0], ADDRESS_STROBE};
            cpu_reset_q <= {cpu_reset_q[0], CPU_RESET};
        end
    end

    // Upper address inputs are captured while the strobe is high, as a
    // transparent latch would, then held for the array once it falls.
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            array_in_q <= 56'h0;
        end
        else if (strobe_q[1])
        begin
            array_in_q <= pin_s;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            addr_latch_q <= 16'h0000;
        end
        else if (strobe_q[1])
        begin
            addr_latch_q <= mux_addr_s;
        end
    end

    assign ARRAY_IN = array_in_q;
    // Ports A to D are all address-in capable; of F only the declared pins.
    assign ADDR_INPUT_FLAG = {8'h00, ADDR_IN_MASK_F, 8'h00, 4'h0, 4'hf, 24'hffffff};
    assign JTAG_ACTIVE = |JTAG_ENABLE_SRC;

    // ******************************************************************
    // Pin drivers
    // ******************************************************************

    logic [7:0] addr_nib_map [3];
    logic periph_buf_enable;
    logic periph_active;
    logic reset_drive;
    logic data_port_read;

    assign addr_nib_map[0] = {addr_latch_q[7:4], BURST_FETCH ? 4'h0 : addr_latch_q[3:0]};
    assign addr_nib_map[1] = {addr_latch_q[7:4], BURST_FETCH ? 4'h0 : addr_latch_q[3:0]};
    assign addr_nib_map[2] = addr_latch_q[15:8];
    assign periph_buf_enable = mem_map_q[PERIPH_BUF_BIT];
    assign periph_active = PERIPHERAL_SELECT_TERM_A || PERIPHERAL_SELECT_TERM_B;
    // Reset pattern only while reset holds and the bus is quiet, to avoid contention.
    assign reset_drive = RESET_PATTERN_MODE && cpu_reset_q[1] && !BUS_CYCLE_ACTIVE;

    genvar p;
    generate
        for (p = 0; p < 7; p++)
        begin : g_port
            logic [7:0] oe;
            logic [7:0] val;
            logic [7:0] pla;
            assign pla = (p == 0) ? PLA_ARRAY_A : (p == 1) ? PLA_ARRAY_B : (p == 2) ? PLA_ARRAY_C : 8'h00;
            if (p < 4)
            begin : g_abcd
                always_comb
                begin
                    oe = dir_q[p] | ARRAY_OE[p*8 +: 8];
                    val = (pla & ARRAY_OUT[p*8 +: 8]) | (~pla & dout_q[p]);
                end
            end
            else
            begin : g_efg
                always_comb
                begin
                    for (int b = 0; b < 8; b++)
                    begin
                        // Driver on when the enable term fires or the direction bit is set; address out only where the control bit is set.
                        if (ARRAY_OE[p*8+b] || (dir_q[p][b] && ctrl_q[p-4][b]))
                        begin
                            oe[b] = 1'b1;
                            val[b] = ctrl_q[p-4][b] ? addr_nib_map[p-4][b] : dout_q[p][b];
                        end
                        else
                        begin
                            oe[b] = dir_q[p][b] && !ctrl_q[p-4][b];
                            val[b] = dout_q[p][b];
                        end
                    end
                    if (p == 5 && periph_buf_enable)
                    begin
                        oe = (periph_active && CPU_DATA_OE) ? 8'hff : 8'h00;
                        val = CPU_DATA_OUT[7:0];
                    end
                    if ((p == 5 || p == 6) && DATA_PORT_MODE)
                    begin
                        oe = CPU_DATA_OE ? 8'hff : 8'h00;
                        val = (p == 6) ? CPU_DATA_OUT[15:8] : CPU_DATA_OUT[7:0];
                    end
                    // The boot pattern wins over every other use of F and G while it is driven.
                    if ((p == 5 || p == 6) && reset_drive)
                    begin
                        oe = 8'hff;
                        val = (p == 6) ? RESET_PATTERN[15:8] : RESET_PATTERN[7:0];
                    end
                end
            end
            assign PIN_OE[p*8 +: 8] = oe;
            assign PIN_OUT[p*8 +: 8] = val;
        end
    endgenerate

    assign data_port_read = DATA_PORT_MODE || periph_buf_enable;
    assign CPU_DATA_IN = data_port_read ? (DATA_PORT_MODE ? pin_s[55:40] : {8'h00, pin_s[47:40]}) : 16'h0000;

endmodule

// File: verilog/pin_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser for a bundle of asynchronous pin levels.
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// File: verilog/port_mode_pkg.sv
package port_mode_pkg;

    // Register byte offsets on the AHB-Lite slave, one aligned word each.
    localparam logic [7:0] OFF_DATA_OUT_A = 8'h00;
    localparam logic [7:0] OFF_DATA_OUT_B = 8'h04;
    localparam logic [7:0] OFF_DATA_OUT_C = 8'h08;
    localparam logic [7:0] OFF_DATA_OUT_D = 8'h0c;
    localparam logic [7:0] OFF_DATA_OUT_E = 8'h10;
    localparam logic [7:0] OFF_DATA_OUT_F = 8'h14;
    localparam logic [7:0] OFF_DATA_OUT_G = 8'h18;
    localparam logic [7:0] OFF_DIR_A = 8'h20;
    localparam logic [7:0] OFF_DIR_B = 8'h24;
    localparam logic [7:0] OFF_DIR_C = 8'h28;
    localparam logic [7:0] OFF_DIR_D = 8'h2c;
    localparam logic [7:0] OFF_DIR_E = 8'h30;
    localparam logic [7:0] OFF_DIR_F = 8'h34;
    localparam logic [7:0] OFF_DIR_G = 8'h38;
    localparam logic [7:0] OFF_CTRL_E = 8'h40;
    localparam logic [7:0] OFF_CTRL_F = 8'h44;
    localparam logic [7:0] OFF_CTRL_G = 8'h48;
    localparam logic [7:0] OFF_MEM_MAP = 8'h50;
    localparam logic [7:0] OFF_PIN_IN_A = 8'h60;
    localparam logic [7:0] OFF_PIN_IN_B = 8'h64;
    localparam logic [7:0] OFF_PIN_IN_C = 8'h68;
    localparam logic [7:0] OFF_PIN_IN_D = 8'h6c;
    localparam logic [7:0] OFF_PIN_IN_E = 8'h70;
    localparam logic [7:0] OFF_PIN_IN_F = 8'h74;
    localparam logic [7:0] OFF_PIN_IN_G = 8'h78;
    localparam logic [7:0] OFF_ADDR_LATCH = 8'h80;

    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam logic [7:0] MEM_MAP_RESET = 8'h00;
    localparam int PERIPH_BUF_BIT = 7;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD = 3'b010;

endpackage
